// >>> common/rtcam_pkg.sv
// rtcam_pkg: register map, field layout, reset values and bus states of the alarm block.
// assumes the timekeeping counters present BCD fields in the same clock domain.
package rtcam_pkg;
    // ----------------------------------------------------------------
    // register offsets on the two-wire bus
    // ----------------------------------------------------------------
    localparam logic [7:0] RTCAM_ALM1_SECOND_OFS   = 8'h08;
    localparam logic [7:0] RTCAM_ALM1_MINUTE_OFS   = 8'h09;
    localparam logic [7:0] RTCAM_ALM1_HOUR_OFS     = 8'h0A; // also elapsed low hour pair
    localparam logic [7:0] RTCAM_ALM1_DAY_OFS      = 8'h0B; // also elapsed mid hour pair
    localparam logic [7:0] RTCAM_ALM1_MONTH_OFS    = 8'h0C; // also elapsed high hour pair
    localparam logic [7:0] RTCAM_ALM2_MINUTE_OFS   = 8'h0D;
    localparam logic [7:0] RTCAM_ALM2_HOUR_OFS     = 8'h0E; // also elapsed low hour pair
    localparam logic [7:0] RTCAM_ALM2_WEEKDAY_OFS  = 8'h0F; // also elapsed mid hour pair
    localparam logic [7:0] RTCAM_ENABLES_OFS       = 8'h10;
    localparam logic [7:0] RTCAM_CONFIG_OFS        = 8'h20;
    localparam logic [7:0] RTCAM_FLAGS_OFS         = 8'h21;
    localparam int         RTCAM_ALM_REGS          = 8;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RTCAM_ALM_RST           = 8'h00;
    localparam logic [7:0] RTCAM_ENABLES_RST       = 8'h00;
    localparam logic [1:0] RTCAM_FLAGS_RST         = 2'h0;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int RTCAM_CFG_MODE_BIT = 0;   // elapsed_mode_select
    localparam int RTCAM_FLG_A1_BIT   = 0;   // alm1_match_flag
    localparam int RTCAM_FLG_A2_BIT   = 1;   // alm2_match_flag
    localparam int RTCAM_EN_A1_LSB    = 0;   // alarm one enables, bits 4..0
    localparam int RTCAM_EN_A2_LSB    = 5;   // alarm two enables, bits 7..5

    // ----------------------------------------------------------------
    // implemented bits of each field
    // ----------------------------------------------------------------
    localparam logic [7:0] RTCAM_SEC_MIN_MASK   = 8'h7F; // tens 6:4, units 3:0
    localparam logic [7:0] RTCAM_HOUR_MASK      = 8'h3F; // meridian or tens high at bit 5
    localparam logic [7:0] RTCAM_DAY_MASK       = 8'h3F; // tens 5:4
    localparam logic [7:0] RTCAM_MONTH_MASK     = 8'h1F; // tens at bit 4
    localparam logic [7:0] RTCAM_WEEKDAY_MASK   = 8'h07; // 0 to 6
    localparam logic [7:0] RTCAM_HOUR_PAIR_MASK = 8'hFF; // two BCD digits
    // per-register masks, offset 08h in the low byte
    localparam logic [63:0] RTCAM_CAL_MASKS = {RTCAM_WEEKDAY_MASK, RTCAM_HOUR_MASK,
        RTCAM_SEC_MIN_MASK, RTCAM_MONTH_MASK, RTCAM_DAY_MASK, RTCAM_HOUR_MASK,
        RTCAM_SEC_MIN_MASK, RTCAM_SEC_MIN_MASK};
    localparam logic [63:0] RTCAM_ELA_MASKS = {RTCAM_HOUR_PAIR_MASK, RTCAM_HOUR_PAIR_MASK,
        RTCAM_SEC_MIN_MASK, RTCAM_HOUR_PAIR_MASK, RTCAM_HOUR_PAIR_MASK, RTCAM_HOUR_PAIR_MASK,
        RTCAM_SEC_MIN_MASK, RTCAM_SEC_MIN_MASK};

    // ----------------------------------------------------------------
    // serial bus
    // ----------------------------------------------------------------
    localparam logic [6:0] RTCAM_DEV_ADDR  = 7'h51;
    localparam logic [3:0] RTCAM_BYTE_BITS = 4'h8;

    typedef enum logic [3:0] {
        RTCAM_ST_IDLE, RTCAM_ST_ADDR, RTCAM_ST_ACK_ADDR, RTCAM_ST_PTR, RTCAM_ST_ACK_PTR,
        RTCAM_ST_WR, RTCAM_ST_ACK_WR, RTCAM_ST_RD, RTCAM_ST_RD_ACK
    } rtcam_bus_state_t;
endpackage

// >>> rtl/rtcam_pin_sync.sv
// rtcam_pin_sync: three-stage synchroniser for one pin with agreement filter.
// assumes the pin is asynchronous to clk_in; idles high like a pulled-up bus line.
`timescale 1ns/100ps
module rtcam_pin_sync (
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    input  wire logic pin_in,
    output logic      level_out
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // first stage feeds only the second; the level moves once stages two and three agree
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s1_r      <= 1'b1;
            s2_r      <= 1'b1;
            s3_r      <= 1'b1;
            level_out <= 1'b1;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_out <= s3_r;
            end
        end
    end
endmodule

// >>> rtl/rtcam_alarm_cmp.sv
// rtcam_alarm_cmp: compares N stored alarm bytes against N current time bytes.
// assumes masks strip unimplemented bits on both sides; purely combinational.
`timescale 1ns/100ps
module rtcam_alarm_cmp #(
    parameter int N = 5
) (
    input  wire logic [N*8-1:0] stored_in,
    input  wire logic [N*8-1:0] current_in,
    input  wire logic [N*8-1:0] mask_in,
    input  wire logic [N-1:0]   enable_in,
    output logic                match_out
);
    logic [N-1:0] field_ok;

    // a disabled field always passes, so only enabled fields decide
    for (genvar i = 0; i < N; i++) begin : g_field
        assign field_ok[i] = ~enable_in[i] |
            ((stored_in[i*8 +: 8] & mask_in[i*8 +: 8]) ==
             (current_in[i*8 +: 8] & mask_in[i*8 +: 8]));
    end

    // an alarm with nothing enabled never fires
    assign match_out = (|enable_in) & (&field_ok);
endmodule

// >>> rtl/rtcam_top.sv
// rtcam_top: two alarm comparators, their registers and flags, behind a two-wire serial slave.
// assumes time fields and the increment tick come from timekeeping logic on clk_in.
`timescale 1ns/100ps
module rtcam_top
    import rtcam_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    input  wire logic       time_tick_in,
    input  wire logic [7:0] cur_second_in,
    input  wire logic [7:0] cur_minute_in,
    input  wire logic [7:0] cur_hour_in,
    input  wire logic [7:0] cur_day_in,
    input  wire logic [7:0] cur_month_in,
    input  wire logic [7:0] cur_weekday_in,
    input  wire logic [7:0] cur_hour_low_pair_in,
    input  wire logic [7:0] cur_hour_mid_pair_in,
    input  wire logic [7:0] cur_hour_high_pair_in,
    output logic            elapsed_mode_select_out,
    output logic            alm1_match_flag_out,
    output logic            alm2_match_flag_out,
    output logic            alm1_irq_pulse_out,
    output logic            alm2_irq_pulse_out
);
    // ----------------------------------------------------------------
    // decoding helpers
    // ----------------------------------------------------------------

    // true when the pointer lands in the alarm byte window 08h..0Fh
    function automatic logic is_alarm(input logic [7:0] ofs);
        return (ofs >= RTCAM_ALM1_SECOND_OFS) && (ofs <= RTCAM_ALM2_WEEKDAY_OFS);
    endfunction

    // implemented bits of an alarm byte in the current mode
    function automatic logic [7:0] alarm_mask(input logic [2:0] idx, input logic ela);
        return ela ? RTCAM_ELA_MASKS[idx*8 +: 8] : RTCAM_CAL_MASKS[idx*8 +: 8];
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic scl_s;
    logic sda_s;
    logic scl_q_r;
    logic sda_q_r;

    rtcam_pin_sync u_scl_sync (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .pin_in     (scl_in),
        .level_out  (scl_s)
    );

    rtcam_pin_sync u_sda_sync (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .pin_in     (sda_in),
        .level_out  (sda_s)
    );

    // previous filtered levels for edge and bus-condition detection
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= scl_s;
            sda_q_r <= sda_s;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    assign scl_rise  = scl_s & ~scl_q_r;
    assign scl_fall  = ~scl_s & scl_q_r;
    assign bus_start = scl_s & scl_q_r & sda_q_r & ~sda_s;
    assign bus_stop  = scl_s & scl_q_r & ~sda_q_r & sda_s;

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    logic [7:0] alm_r [RTCAM_ALM_REGS];
    logic [7:0] enables_r;
    logic       mode_r;
    logic [1:0] flags_r;

    // write strobe from the serial slave
    logic       wr_stb;
    logic [7:0] wr_ofs;
    logic [7:0] wr_data;

    // read data for the byte at the pointer
    function automatic logic [7:0] read_reg(input logic [7:0] ofs);
        logic [7:0] v;
        v = 8'h00;
        if (is_alarm(ofs)) begin
            v = alm_r[ofs[2:0]] & alarm_mask(ofs[2:0], mode_r);
        end else if (ofs == RTCAM_ENABLES_OFS) begin
            v = enables_r;
        end else if (ofs == RTCAM_CONFIG_OFS) begin
            v = {7'h00, mode_r};
        end else if (ofs == RTCAM_FLAGS_OFS) begin
            v = {6'h00, flags_r};
        end
        return v;
    endfunction

    // masked storage
    // unimplemented bits are dropped on write so they can never read back or compare
    for (genvar i = 0; i < RTCAM_ALM_REGS; i++) begin : g_alm
        always_ff @(posedge clk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                alm_r[i] <= RTCAM_ALM_RST;
            end else if (wr_stb && is_alarm(wr_ofs) && (wr_ofs[2:0] == 3'(i))) begin
                alm_r[i] <= wr_data & alarm_mask(3'(i), mode_r);
            end
        end
    end

    // enable register reset
    // one enable bit per field, all disabled out of reset
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            enables_r <= RTCAM_ENABLES_RST;
        end else if (wr_stb && (wr_ofs == RTCAM_ENABLES_OFS)) begin
            enables_r <= wr_data;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mode_r <= 1'b0;
        end else if (wr_stb && (wr_ofs == RTCAM_CONFIG_OFS)) begin
            mode_r <= wr_data[RTCAM_CFG_MODE_BIT];
        end
    end

    // ----------------------------------------------------------------
    // alarm comparison
    // ----------------------------------------------------------------
    logic [39:0] a1_cur;
    logic [39:0] a1_mask;
    logic [23:0] a2_cur;
    logic [23:0] a2_mask;
    logic        a1_match;
    logic        a2_match;

    // hour format
    // hour bits 5:0 carry either meridian plus one tens bit or two tens bits;
    // the counters use the same layout, so a direct compare covers both formats
    always_comb begin
        if (mode_r) begin
            a1_cur = {cur_hour_high_pair_in, cur_hour_mid_pair_in, cur_hour_low_pair_in,
                      cur_minute_in, cur_second_in};
            a2_cur = {cur_hour_mid_pair_in, cur_hour_low_pair_in, cur_minute_in};
        end else begin
            a1_cur = {cur_month_in, cur_day_in, cur_hour_in, cur_minute_in, cur_second_in};
            a2_cur = {cur_weekday_in, cur_hour_in, cur_minute_in};
        end
    end

    assign a1_mask = mode_r ? RTCAM_ELA_MASKS[39:0]  : RTCAM_CAL_MASKS[39:0];
    assign a2_mask = mode_r ? RTCAM_ELA_MASKS[63:40] : RTCAM_CAL_MASKS[63:40];

    rtcam_alarm_cmp #(.N(5)) u_alm1_cmp (
        .stored_in  ({alm_r[4], alm_r[3], alm_r[2], alm_r[1], alm_r[0]}),
        .current_in (a1_cur),
        .mask_in    (a1_mask),
        .enable_in  (enables_r[RTCAM_EN_A1_LSB +: 5]),
        .match_out  (a1_match)
    );

    rtcam_alarm_cmp #(.N(3)) u_alm2_cmp (
        .stored_in  ({alm_r[7], alm_r[6], alm_r[5]}),
        .current_in (a2_cur),
        .mask_in    (a2_mask),
        .enable_in  (enables_r[RTCAM_EN_A2_LSB +: 3]),
        .match_out  (a2_match)
    );

    // tick qualified
    // a register write alone never fires an alarm, only an increment does
    logic a1_hit;
    logic a2_hit;
    assign a1_hit = time_tick_in & a1_match;
    assign a2_hit = time_tick_in & a2_match;

    // sticky until cleared
    // the host writes 0 to a flag bit to clear it; a hit in the same cycle wins
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            flags_r <= RTCAM_FLAGS_RST;
        end else begin
            if (a1_hit) begin
                flags_r[RTCAM_FLG_A1_BIT] <= 1'b1;
            end else if (wr_stb && (wr_ofs == RTCAM_FLAGS_OFS) && !wr_data[RTCAM_FLG_A1_BIT]) begin
                flags_r[RTCAM_FLG_A1_BIT] <= 1'b0;
            end
            if (a2_hit) begin
                flags_r[RTCAM_FLG_A2_BIT] <= 1'b1;
            end else if (wr_stb && (wr_ofs == RTCAM_FLAGS_OFS) && !wr_data[RTCAM_FLG_A2_BIT]) begin
                flags_r[RTCAM_FLG_A2_BIT] <= 1'b0;
            end
        end
    end

    // interrupt request
    // one pulse per matching increment, repeated even while the flag is still set
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            alm1_irq_pulse_out <= 1'b0;
            alm2_irq_pulse_out <= 1'b0;
        end else begin
            alm1_irq_pulse_out <= a1_hit;
            alm2_irq_pulse_out <= a2_hit;
        end
    end

    // status outputs follow the flags and mode one cycle later
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            alm1_match_flag_out     <= 1'b0;
            alm2_match_flag_out     <= 1'b0;
            elapsed_mode_select_out <= 1'b0;
        end else begin
            alm1_match_flag_out     <= flags_r[RTCAM_FLG_A1_BIT];
            alm2_match_flag_out     <= flags_r[RTCAM_FLG_A2_BIT];
            elapsed_mode_select_out <= mode_r;
        end
    end

    // ----------------------------------------------------------------
    // two-wire serial slave
    // ----------------------------------------------------------------
    rtcam_bus_state_t state_r;
    logic [7:0]       shift_r;
    logic [3:0]       bits_r;
    logic [7:0]       ptr_r;
    logic             rw_r;
    logic             mack_r;
    logic [7:0]       rd_now;

    // byte at the pointer for the read path; a process, so it follows storage changes too
    always_comb begin
        rd_now = read_reg(ptr_r);
    end

    assign wr_stb  = (state_r == RTCAM_ST_WR) && scl_fall && (bits_r == RTCAM_BYTE_BITS);
    assign wr_ofs  = ptr_r;
    assign wr_data = shift_r;

    // data is sampled on scl rising and the slave changes sda only on scl falling,
    // so sda never moves while scl is high; no clock stretching is done
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_r    <= RTCAM_ST_IDLE;
            shift_r    <= 8'h00;
            bits_r     <= 4'h0;
            ptr_r      <= 8'h00;
            rw_r       <= 1'b0;
            mack_r     <= 1'b0;
            sda_oe_out <= 1'b0;
        end else if (bus_start) begin
            state_r    <= RTCAM_ST_ADDR;
            bits_r     <= 4'h0;
            sda_oe_out <= 1'b0;
        end else if (bus_stop) begin
            state_r    <= RTCAM_ST_IDLE;
            sda_oe_out <= 1'b0;
        end else if (scl_rise) begin
            if (state_r == RTCAM_ST_RD_ACK) begin
                mack_r <= ~sda_s;
            end else if (state_r inside {RTCAM_ST_ADDR, RTCAM_ST_PTR, RTCAM_ST_WR}) begin
                shift_r <= {shift_r[6:0], sda_s};
                bits_r  <= bits_r + 4'h1;
            end
        end else if (scl_fall) begin
            unique case (state_r)
                RTCAM_ST_IDLE: begin
                    sda_oe_out <= 1'b0;
                end
                RTCAM_ST_ADDR: begin
                    if (bits_r == RTCAM_BYTE_BITS) begin
                        if (shift_r[7:1] == RTCAM_DEV_ADDR) begin
                            rw_r       <= shift_r[0];
                            sda_oe_out <= 1'b1;
                            state_r    <= RTCAM_ST_ACK_ADDR;
                        end else begin
                            state_r <= RTCAM_ST_IDLE;
                        end
                    end
                end
                RTCAM_ST_ACK_ADDR: begin
                    bits_r <= 4'h0;
                    if (rw_r) begin
                        // first read byte comes from the current pointer
                        shift_r    <= {rd_now[6:0], 1'b0};
                        sda_oe_out <= ~rd_now[7];
                        ptr_r      <= ptr_r + 8'h01;
                        bits_r     <= 4'h1;
                        state_r    <= RTCAM_ST_RD;
                    end else begin
                        sda_oe_out <= 1'b0;
                        state_r    <= RTCAM_ST_PTR;
                    end
                end
                RTCAM_ST_PTR: begin
                    if (bits_r == RTCAM_BYTE_BITS) begin
                        ptr_r      <= shift_r;
                        sda_oe_out <= 1'b1;
                        state_r    <= RTCAM_ST_ACK_PTR;
                    end
                end
                RTCAM_ST_WR: begin
                    // the write strobe fires here; pointer advances for burst writes
                    if (bits_r == RTCAM_BYTE_BITS) begin
                        ptr_r      <= ptr_r + 8'h01;
                        sda_oe_out <= 1'b1;
                        state_r    <= RTCAM_ST_ACK_WR;
                    end
                end
                RTCAM_ST_ACK_PTR, RTCAM_ST_ACK_WR: begin
                    sda_oe_out <= 1'b0;
                    bits_r     <= 4'h0;
                    state_r    <= RTCAM_ST_WR;
                end
                RTCAM_ST_RD: begin
                    if (bits_r == RTCAM_BYTE_BITS) begin
                        sda_oe_out <= 1'b0;
                        state_r    <= RTCAM_ST_RD_ACK;
                    end else begin
                        sda_oe_out <= ~shift_r[7];
                        shift_r    <= {shift_r[6:0], 1'b0};
                        bits_r     <= bits_r + 4'h1;
                    end
                end
                RTCAM_ST_RD_ACK: begin
                    if (mack_r) begin
                        shift_r    <= {rd_now[6:0], 1'b0};
                        sda_oe_out <= ~rd_now[7];
                        ptr_r      <= ptr_r + 8'h01;
                        bits_r     <= 4'h1;
                        state_r    <= RTCAM_ST_RD;
                    end else begin
                        state_r <= RTCAM_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // open-drain data line only ever pulls low
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end
endmodule

// >>> verification/rtcam_properties.sv
// rtcam_properties: flag, pulse and bus drive timing of the alarm block.
// assumes it is bound to rtcam_top and sees only its ports.
`timescale 1ns/100ps
module rtcam_properties (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic time_tick_in,
    input wire logic alm1_match_flag_out,
    input wire logic alm2_match_flag_out,
    input wire logic alm1_irq_pulse_out,
    input wire logic alm2_irq_pulse_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // a flag going from clear to set
    sequence s_set1; !alm1_match_flag_out ##1 alm1_match_flag_out; endsequence
    sequence s_set2; !alm2_match_flag_out ##1 alm2_match_flag_out; endsequence
    a_irq1_cause: assert property (alm1_irq_pulse_out |-> $past(time_tick_in))
        else $error("irq1 without tick");
    a_irq2_cause: assert property (alm2_irq_pulse_out |-> $past(time_tick_in))
        else $error("irq2 without tick");
    // flag output rises the cycle after its pulse
    a_flag1_set: assert property (s_set1 |-> $past(alm1_irq_pulse_out))
        else $error("flag1 set without match");
    a_flag2_set: assert property (s_set2 |-> $past(alm2_irq_pulse_out))
        else $error("flag2 set without match");
    // alarm one pulse lasts one cycle, alarm two flag set
    a_irq1_width: assert property (alm1_irq_pulse_out |=> !alm1_irq_pulse_out)
        else $error("irq1 pulse too long");
    a_irq2_flag: assert property (alm2_irq_pulse_out |=> alm2_match_flag_out)
        else $error("irq2 without flag2");
    // bus drive: open drain, starts in scl low phase
    a_sda_low_only: assert property (sda_oe_out |-> !sda_out)
        else $error("sda driven high");
    a_oe_scl_low: assert property ($rose(sda_oe_out) |-> !scl_in)
        else $error("sda drive began with scl high");
endmodule

// >>> verification/rtcam_host.sv
// rtcam_host: two-wire host that writes and reads the device registers.
// assumes the bench resolves sda as a pulled-up open-drain line.
`timescale 1ns/100ps
module rtcam_host
    import rtcam_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       sda_line_in,
    output logic            scl_out = 1'b1,
    output logic            sda_low_out = 1'b0,
    output logic            rd_valid_out = 1'b0,
    output logic [7:0]      rd_byte_out = 8'h00
);
    logic smp;
    // one 8-clock phase; sda sampled mid-phase
    task automatic ph(input logic c, input logic l);
        scl_out = c;
        sda_low_out = l;
        repeat (4) @(negedge clk_in);
        smp = sda_line_in;
        repeat (4) @(negedge clk_in);
    endtask
    // scl falls alone first, so sda is released while scl is low and only falls once scl is high
    task automatic start();
        ph(1'b0, sda_low_out);
        ph(1'b0, 1'b0);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);
    endtask
    task automatic stop();
        ph(1'b0, sda_low_out);
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);
    endtask
    // eight bits then the acknowledge bit, msb first
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            ph(1'b0, sda_low_out);
            ph(1'b0, !d[i]);
            ph(1'b1, !d[i]);
            q[i] = smp;
        end
    endtask
    // host writes only the byte it names
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic [8:0] q;
        start();
        xfer({RTCAM_DEV_ADDR, 2'b01}, q);
        xfer({a, 1'b1}, q);
        xfer({v, 1'b1}, q);
        stop();
    endtask
    // last byte is not acknowledged, ending the read
    task automatic rd(input logic [7:0] a);
        logic [8:0] q;
        start();
        xfer({RTCAM_DEV_ADDR, 2'b01}, q);
        xfer({a, 1'b1}, q);
        start();
        xfer({RTCAM_DEV_ADDR, 2'b11}, q);
        xfer(9'h1FF, q);
        stop();
        rd_byte_out = q[8:1];
        // valid moves on the rising edge so the falling-edge checker sees it settled
        @(posedge clk_in);
        rd_valid_out = 1'b1;
        @(posedge clk_in);
        rd_valid_out = 1'b0;
        @(negedge clk_in);
    endtask
endmodule

// >>> verification/rtc_alarm_match_tb.sv
// rtc_alarm_match_tb: bus accesses and time ticks against queued expectations.
// assumes rtcam_host and rtcam_properties are compiled before it.
`timescale 1ns/100ps
module rtc_alarm_match_tb
    import rtcam_pkg::*;
;
    logic       clk_in = 1'b0;
    logic       sys_rst_in = 1'b1;
    logic       tick_r = 1'b0;
    logic [71:0] cur;
    logic [7:0] tick_v = 8'h00;
    int         tick_f = 0;
    logic       tick_req = 1'b0;
    logic       scl, sda_low, rd_valid, sda_out, sda_oe, mode;
    logic [7:0] rd_byte, got;
    logic [1:0] irq, flg;
    logic [7:0] exp_q [$];
    int         err_total = 0;
    int         checks_done = 0;
    integer     seed = 62;
    wire        sda_line = !(sda_low || (sda_oe && !sda_out));
    always #12.5 clk_in = ~clk_in;
    rtcam_top rtcam_top_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe_out(sda_oe), .time_tick_in(tick_r),
        .cur_second_in(cur[7:0]), .cur_minute_in(cur[15:8]), .cur_hour_in(cur[23:16]),
        .cur_day_in(cur[31:24]), .cur_month_in(cur[39:32]), .cur_weekday_in(cur[47:40]),
        .cur_hour_low_pair_in(cur[55:48]), .cur_hour_mid_pair_in(cur[63:56]),
        .cur_hour_high_pair_in(cur[71:64]), .elapsed_mode_select_out(mode),
        .alm1_match_flag_out(flg[0]), .alm2_match_flag_out(flg[1]),
        .alm1_irq_pulse_out(irq[0]), .alm2_irq_pulse_out(irq[1]));
    rtcam_host rtcam_host_inst (.clk_in(clk_in), .sda_line_in(sda_line), .scl_out(scl),
        .sda_low_out(sda_low), .rd_valid_out(rd_valid), .rd_byte_out(rd_byte));
    task automatic check(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic finish_test();
        if (err_total == 0 && checks_done > 0 && exp_q.size() == 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // an irq pulse or a read byte retires the oldest note
    always @(negedge clk_in) begin
        if (irq != 2'b00 || rd_valid) begin
            got = rd_valid ? rd_byte : {6'h00, irq};
            check(got, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
        end
    end
    // random time fields every cycle, field tick_f held at tick_v; tick_r follows the request
    always @(negedge clk_in) begin
        for (int i = 0; i < 9; i++) begin
            cur[i*8 +: 8] <= 8'($random(seed));
        end
        cur[tick_f*8 +: 8] <= tick_v;
        tick_r <= tick_req;
    end
    // request on the rising edge so the falling-edge driver sees it settled
    task automatic tick(input int f, input logic [7:0] v);
        @(posedge clk_in);
        tick_f = f;
        tick_v = v;
        tick_req = 1'b1;
        @(posedge clk_in);
        tick_req = 1'b0;
        repeat (4) @(negedge clk_in);
    endtask
    initial begin
        repeat (5) @(negedge clk_in);
        sys_rst_in = 1'b0;
        repeat (8) @(negedge clk_in);
        exp_q.push_back(8'h00);
        rtcam_host_inst.rd(8'h10);
        exp_q.push_back(8'h00);
        rtcam_host_inst.rd(8'h21);
        for (int i = 0; i < RTCAM_ALM_REGS; i++) begin
            rtcam_host_inst.wr(8'h08 + 8'(i), 8'hFF);
            exp_q.push_back(RTCAM_CAL_MASKS[i*8 +: 8]);
            rtcam_host_inst.rd(8'h08 + 8'(i));
        end
        // a matching write alone raises nothing
        tick_v = 8'h45;
        rtcam_host_inst.wr(8'h08, 8'h45);
        rtcam_host_inst.wr(8'h10, 8'h01);
        tick(0, 8'h44);
        exp_q.push_back(8'h01);
        tick(0, 8'h45);
        exp_q.push_back(8'h01);
        tick(0, 8'h45);
        exp_q.push_back(8'h01);
        rtcam_host_inst.rd(8'h21);
        check({6'h00, flg}, 8'h01);
        rtcam_host_inst.wr(8'h21, 8'h02);
        exp_q.push_back(8'h00);
        rtcam_host_inst.rd(8'h21);
        check({6'h00, flg}, 8'h00);
        rtcam_host_inst.wr(8'h0F, 8'h05);
        rtcam_host_inst.wr(8'h10, 8'h80);
        tick(5, 8'h04);
        exp_q.push_back(8'h02);
        tick(5, 8'h05);
        check({6'h00, flg}, 8'h02);
        rtcam_host_inst.wr(8'h21, 8'h00);
        rtcam_host_inst.wr(8'h20, 8'h01);
        check({7'h00, mode}, 8'h01);
        rtcam_host_inst.wr(8'h0C, 8'h99);
        exp_q.push_back(8'h99);
        rtcam_host_inst.rd(8'h0C);
        rtcam_host_inst.wr(8'h10, 8'h10);
        exp_q.push_back(8'h01);
        tick(8, 8'h99);
        rtcam_host_inst.wr(8'h0D, 8'h30);
        rtcam_host_inst.wr(8'h10, 8'h20);
        exp_q.push_back(8'h02);
        tick(1, 8'h30);
        repeat (8) @(negedge clk_in);
        finish_test();
    end
    // the run needs about 26000 cycles
    initial begin
        repeat (60000) @(posedge clk_in);
        err_total++;
        finish_test();
    end
endmodule
bind rtcam_top rtcam_properties rtcam_properties_inst (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .scl_in(scl_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .time_tick_in(time_tick_in), .alm1_match_flag_out(alm1_match_flag_out),
    .alm2_match_flag_out(alm2_match_flag_out), .alm1_irq_pulse_out(alm1_irq_pulse_out),
    .alm2_irq_pulse_out(alm2_irq_pulse_out));
